/* File: logic/kcm_menu.sv */
// keypad configuration menu with parameter store and ahb-lite access
`timescale 1ns/100ps
`default_nettype none
`include "kcm_regs.svh"
module kcm_menu
    import kcm_pkg::*;
#(
    parameter logic FAST_VARIANT = 1'b0
) (
    // clock, reset, enable
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic        hreadyout,
    output var  logic        hresp,
    output var  logic [31:0] hrdata,
    // keypad and sensor pins
    input  wire kcm_keys_t   key_pins,
    input  wire logic        document_pin,
    input  wire logic        lid_closed_pin,
    // storage
    input  wire kcm_nvm_t    nvm_ld,
    output var  kcm_nvm_t    nvm_wr,
    // host, printer and display
    output var  kcm_host_t   host_out,
    output var  logic        print_list_req,
    output var  logic [1:0]  print_list_cat,
    output var  logic        menu_active,
    output var  logic [5:0]  disp_idx,
    output var  logic [7:0]  disp_value,
    output var  logic        print_inhibit,
    output var  logic        paper_empty,
    output var  logic        online
);
    // ==================================
    // choice ranges per parameter
    function automatic logic [7:0] pmax(input logic [5:0] i);
        unique case (i)
            `KCM_IDX_CPI, `KCM_IDX_QUALITY, `KCM_IDX_PARITY: pmax = 8'h02;
            `KCM_IDX_INS_START, `KCM_IDX_PROTO, `KCM_IDX_EMUL: pmax = 8'h03;
            `KCM_IDX_FIRST_LINE: pmax = `KCM_FIRST_LINE_MAX;
            `KCM_IDX_BAUD: pmax = FAST_VARIANT ? 8'h04 : 8'h03;
            `KCM_IDX_DARK_NORMAL,
            `KCM_IDX_CORRESPONDENCE_QUALITY_DARK: pmax = `KCM_DARK_MAX;
            default: pmax = (i >= `KCM_BASE_SRV && i < `KCM_BASE_OVR) ?
                            `KCM_SERVICE_MAX : 8'h01;
        endcase
    endfunction

    // lowest choice; 1200 baud missing on the fast variant
    function automatic logic [7:0] pmin(input logic [5:0] i);
        pmin = (i == `KCM_IDX_BAUD && FAST_VARIANT) ? 8'h01 : 8'h00;
    endfunction

    function automatic logic [5:0] cat_base(input kcm_cat_t c);
        unique case (c)
            kcm_cat_prn: cat_base = `KCM_BASE_PRN;
            kcm_cat_com: cat_base = `KCM_BASE_COM;
            kcm_cat_srv: cat_base = `KCM_BASE_SRV;
            kcm_cat_ovr: cat_base = `KCM_BASE_OVR;
        endcase
    endfunction

    function automatic logic [5:0] cat_last(input kcm_cat_t c);
        unique case (c)
            kcm_cat_prn: cat_last = `KCM_LAST_PRN;
            kcm_cat_com: cat_last = `KCM_LAST_COM;
            kcm_cat_srv: cat_last = `KCM_LAST_SRV;
            kcm_cat_ovr: cat_last = `KCM_LAST_OVR;
        endcase
    endfunction

    // reset contents; service config field stays 00
    function automatic logic [7:0] pdef(input int i);
        if (i == int'(`KCM_IDX_FIRST_LINE)) pdef = `KCM_FIRST_LINE_RST;
        else if (i == int'(`KCM_IDX_BAUD)) pdef = `KCM_BAUD_RST;
        else pdef = 8'h00;
    endfunction

    // ==================================
    // pin synchronisers
    kcm_keys_t  key_s1_reg, key_s2_reg, key_s3_reg;
    logic [1:0] document_s_reg, lid_s_reg;
    logic       lid_d_reg;

    // second stage only feeds logic; third stage gives edges
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            key_s1_reg     <= '0;
            key_s2_reg     <= '0;
            key_s3_reg     <= '0;
            document_s_reg <= 2'h0;
            lid_s_reg      <= 2'h3;
            lid_d_reg      <= 1'b1;
        end else if (ce) begin
            key_s1_reg     <= key_pins;
            key_s2_reg     <= key_s1_reg;
            key_s3_reg     <= key_s2_reg;
            document_s_reg <= {document_s_reg[0], document_pin};
            lid_s_reg      <= {lid_s_reg[0], lid_closed_pin};
            lid_d_reg      <= lid_s_reg[1];
        end
    end

    logic dig_p, fn_p, up_p, ent_p, clr_p, lid_rise, document_ok, lid_ok;
    assign dig_p       = key_s2_reg.digit_hit & ~key_s3_reg.digit_hit;
    assign fn_p        = key_s2_reg.function_code_key & ~key_s3_reg.function_code_key;
    assign up_p        = key_s2_reg.up & ~key_s3_reg.up;
    assign ent_p       = key_s2_reg.enter & ~key_s3_reg.enter;
    assign clr_p       = key_s2_reg.clear & ~key_s3_reg.clear;
    assign lid_rise    = lid_s_reg[1] & ~lid_d_reg;
    assign document_ok = document_s_reg[1];
    assign lid_ok      = lid_s_reg[1];

    // ==================================
    // ahb-lite slave: writes zero wait, reads one wait state
    logic        ap, rdp_reg, rdp_next, wrp_reg, wrp_next, hready_reg, hready_next;
    logic [7:0]  addr_reg, addr_next;
    logic [31:0] hrdata_reg, hrdata_next, rd_mux;
    logic [5:0]  pidx_reg, pidx_next;
    logic        pd_we;
    kcm_state_t  st_reg, st_next;
    kcm_cat_t    cat_reg, cat_next;
    logic [5:0]  idx_reg, idx_next;
    logic [7:0]  prm_reg [`KCM_NPARAM];
    logic [7:0]  prm_next [`KCM_NPARAM];
    kcm_host_t   host_reg, host_next;

    assign ap    = hsel & htrans[1] & hready;
    // a bad value is dropped rather than stored out of range
    assign pd_we = wrp_reg && addr_reg == `KCM_ADDR_PDATA &&
                   hwdata[7:0] <= pmax(pidx_reg) && hwdata[7:0] >= pmin(pidx_reg);

    // read mux, evaluated in the wait cycle so a prior write has landed
    always_comb begin
        unique case (addr_reg)
            `KCM_ADDR_STATUS: rd_mux = {19'h0, st_reg == kcm_st_menu, cat_reg, idx_reg,
                                        document_ok, lid_ok, prm_reg[`KCM_IDX_LOCK][0],
                                        prm_reg[`KCM_IDX_COVER][0]};
            `KCM_ADDR_PIDX:   rd_mux = {26'h0, pidx_reg};
            `KCM_ADDR_PDATA:  rd_mux = {24'h0, prm_reg[pidx_reg]};
            `KCM_ADDR_HOST:   rd_mux = {18'h0, host_reg.len, host_reg.code};
            default:          rd_mux = 32'h0;
        endcase
    end

    // bus phase tracking
    always_comb begin
        rdp_next    = ap & ~hwrite;
        wrp_next    = ap & hwrite;
        hready_next = ~(ap & ~hwrite);
        addr_next   = ap ? haddr[7:0] : addr_reg;
        hrdata_next = rdp_reg ? rd_mux : hrdata_reg;
        pidx_next   = pidx_reg;
        if (wrp_reg && addr_reg == `KCM_ADDR_PIDX && hwdata[5:0] < 6'(`KCM_NPARAM)) begin
            pidx_next = hwdata[5:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdp_reg    <= 1'b0;
            wrp_reg    <= 1'b0;
            hready_reg <= 1'b1;
            addr_reg   <= 8'h00;
            hrdata_reg <= 32'h0;
            pidx_reg   <= 6'h00;
        end else if (ce) begin
            rdp_reg    <= rdp_next;
            wrp_reg    <= wrp_next;
            hready_reg <= hready_next;
            addr_reg   <= addr_next;
            hrdata_reg <= hrdata_next;
            pidx_reg   <= pidx_next;
        end
    end

    assign hreadyout = hready_reg;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_reg;

    // ==================================
    // key entry, menu walk and parameter store
    logic [2:0][3:0] dig_reg, dig_next;
    logic [1:0]      dcnt_reg, dcnt_next;
    kcm_nvm_t        nvm_reg, nvm_next;
    logic            preq_reg, preq_next;
    logic [1:0]      pcat_reg, pcat_next;
    logic [7:0]      dval_reg, dval_next, cur_val;
    logic            paper_reg, paper_next, online_reg, online_next;
    logic            inh_reg, inh_next, up_ok;

    assign cur_val = prm_reg[idx_reg];
    // the lock entry itself stays editable so the keypad can be unlocked
    assign up_ok   = prm_reg[`KCM_IDX_LOCK] == 8'h00 || idx_reg == `KCM_IDX_LOCK;

    always_comb begin
        st_next   = st_reg;
        cat_next  = cat_reg;
        idx_next  = idx_reg;
        dig_next  = dig_reg;
        dcnt_next = dcnt_reg;
        for (int i = 0; i < `KCM_NPARAM; i++) begin
            prm_next[i] = prm_reg[i];
        end
        nvm_next        = '0;
        host_next       = host_reg;
        host_next.valid = 1'b0;
        preq_next       = 1'b0;
        pcat_next       = pcat_reg;
        // stored values come back after power-up
        if (nvm_ld.we && nvm_ld.addr < 6'(`KCM_NPARAM)) begin
            prm_next[nvm_ld.addr] = nvm_ld.data;
        end
        if (pd_we) begin
            prm_next[pidx_reg] = hwdata[7:0];
            nvm_next = '{we: 1'b1, addr: pidx_reg, data: hwdata[7:0]};
        end
        unique case (st_reg)
            kcm_st_idle: begin
                if (clr_p) begin
                    dcnt_next = 2'd0;
                end else if (dig_p && dcnt_reg != 2'd3) begin
                    dig_next[dcnt_reg] = key_s2_reg.digit;
                    dcnt_next = dcnt_reg + 2'd1;
                end else if (fn_p) begin
                    dcnt_next = 2'd0;
                    if (dcnt_reg != 2'd0 && dig_reg[0] != `KCM_INTERNAL_DIGIT) begin
                        host_next = '{valid: 1'b1, len: dcnt_reg, code: dig_reg};
                    end else if (dcnt_reg == 2'd2) begin
                        st_next = kcm_st_menu;
                        unique case (dig_reg[1])
                            `KCM_CODE_PRN: cat_next = kcm_cat_prn;
                            `KCM_CODE_COM: cat_next = kcm_cat_com;
                            `KCM_CODE_SRV: cat_next = kcm_cat_srv;
                            `KCM_CODE_OVR: cat_next = kcm_cat_ovr;
                            default:       st_next  = kcm_st_idle;
                        endcase
                        idx_next = cat_base(cat_next);
                    end else if (dcnt_reg == 2'd3 && dig_reg[1] == `KCM_PRINT_DIGIT &&
                                 dig_reg[2] == `KCM_PRINT_DIGIT) begin
                        preq_next = 1'b1;
                        pcat_next = cat_reg;
                    end
                end
            end
            kcm_st_menu: begin
                if (up_p && up_ok) begin
                    prm_next[idx_reg] = (cur_val >= pmax(idx_reg)) ? pmin(idx_reg)
                                                                   : cur_val + 8'h01;
                    nvm_next = '{we: 1'b1, addr: idx_reg, data: prm_next[idx_reg]};
                end else if (ent_p) begin
                    if (idx_reg == cat_last(cat_reg)) begin
                        st_next = kcm_st_idle;
                    end else if (idx_reg == `KCM_IDX_PROTO &&
                                 cur_val == `KCM_PROTO_PARALLEL) begin
                        idx_next = idx_reg + `KCM_SERIAL_SKIP;
                    end else begin
                        idx_next = idx_reg + 6'd1;
                    end
                end
            end
        endcase
        // lid event last so it wins over a key or bus edit in the same cycle
        if (lid_rise) begin
            prm_next[`KCM_IDX_COVER] = 8'h00;
            nvm_next = '{we: 1'b1, addr: `KCM_IDX_COVER, data: 8'h00};
        end
        dval_next   = prm_next[idx_next];
        paper_next  = prm_reg[`KCM_IDX_PAPER_OUT] == `KCM_NO_DOCUMENT_CHOICE &&
                      !document_ok;
        online_next = prm_reg[`KCM_IDX_SELECT] != `KCM_DOCUMENT_PRESENT_CHOICE ||
                      document_ok;
        inh_next    = !lid_ok && prm_reg[`KCM_IDX_COVER] == 8'h00;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg     <= kcm_st_idle;
            cat_reg    <= kcm_cat_prn;
            idx_reg    <= 6'h00;
            dig_reg    <= '0;
            dcnt_reg   <= 2'd0;
            for (int i = 0; i < `KCM_NPARAM; i++) begin
                prm_reg[i] <= pdef(i);
            end
            nvm_reg    <= '0;
            host_reg   <= '0;
            preq_reg   <= 1'b0;
            pcat_reg   <= 2'd0;
            dval_reg   <= 8'h00;
            paper_reg  <= 1'b0;
            online_reg <= 1'b1;
            inh_reg    <= 1'b0;
        end else if (ce) begin
            st_reg     <= st_next;
            cat_reg    <= cat_next;
            idx_reg    <= idx_next;
            dig_reg    <= dig_next;
            dcnt_reg   <= dcnt_next;
            for (int i = 0; i < `KCM_NPARAM; i++) begin
                prm_reg[i] <= prm_next[i];
            end
            nvm_reg    <= nvm_next;
            host_reg   <= host_next;
            preq_reg   <= preq_next;
            pcat_reg   <= pcat_next;
            dval_reg   <= dval_next;
            paper_reg  <= paper_next;
            online_reg <= online_next;
            inh_reg    <= inh_next;
        end
    end

    assign nvm_wr         = nvm_reg;
    assign host_out       = host_reg;
    assign print_list_req = preq_reg;
    assign print_list_cat = pcat_reg;
    assign menu_active    = st_reg == kcm_st_menu;
    assign disp_idx       = idx_reg;
    assign disp_value     = dval_reg;
    assign print_inhibit  = inh_reg;
    assign paper_empty    = paper_reg;
    assign online         = online_reg;

    // ==================================
    // checks
    logic quiet_edit;
    assign quiet_edit = !pd_we && !nvm_ld.we && !lid_rise;

    // a clear edge, or a digit edge with fewer than three digits held, in the same cycle takes priority over the function key
    sequence s_internal_code;
        ce && st_reg == kcm_st_idle && fn_p && !clr_p && !dig_p &&
        dig_reg[0] == `KCM_INTERNAL_DIGIT;
    endsequence

    property p_cat_ovr;
        @(posedge hclk) disable iff (!hresetn)
        s_internal_code and (dcnt_reg == 2'd2 && dig_reg[1] == `KCM_CODE_OVR)
        |=> st_reg == kcm_st_menu && idx_reg == `KCM_BASE_OVR;
    endproperty
    a_cat_ovr: assert property (p_cat_ovr) else $error("override category not entered");

    property p_print_list;
        @(posedge hclk) disable iff (!hresetn)
        s_internal_code and (dcnt_reg == 2'd3 && dig_reg[1] == 4'h0 && dig_reg[2] == 4'h0)
        |=> print_list_req ##1 (!print_list_req || !$past(ce));
    endproperty
    a_print_list: assert property (p_print_list) else $error("print request not one pulse");

    property p_host_fwd;
        @(posedge hclk) disable iff (!hresetn)
        ce && st_reg == kcm_st_idle && fn_p && !clr_p && !dig_p && dcnt_reg != 2'd0 &&
        dig_reg[0] != `KCM_INTERNAL_DIGIT |=> host_out.valid && host_out.len == $past(dcnt_reg);
    endproperty
    a_host_fwd: assert property (p_host_fwd) else $error("host code not forwarded");

    property p_wrap;
        @(posedge hclk) disable iff (!hresetn)
        ce && st_reg == kcm_st_menu && up_p && up_ok && quiet_edit &&
        cur_val == pmax(idx_reg) |=> cur_val == pmin(idx_reg) && nvm_wr.we;
    endproperty
    a_wrap: assert property (p_wrap) else $error("choice did not wrap");

    property p_locked;
        @(posedge hclk) disable iff (!hresetn)
        ce && st_reg == kcm_st_menu && up_p && !up_ok && quiet_edit
        |=> $stable(cur_val) && !nvm_wr.we;
    endproperty
    a_locked: assert property (p_locked) else $error("locked value changed");

    property p_skip;
        @(posedge hclk) disable iff (!hresetn)
        ce && st_reg == kcm_st_menu && ent_p && !(up_p && up_ok) && idx_reg == `KCM_IDX_PROTO &&
        cur_val == `KCM_PROTO_PARALLEL |=> idx_reg == `KCM_IDX_PROTO + `KCM_SERIAL_SKIP;
    endproperty
    a_skip: assert property (p_skip) else $error("serial items not skipped");

    property p_paper;
        @(posedge hclk) disable iff (!hresetn)
        ce |=> paper_empty == $past(prm_reg[`KCM_IDX_PAPER_OUT] == 8'h00 && !document_ok);
    endproperty
    a_paper: assert property (p_paper) else $error("paper empty wrong");

    property p_online;
        @(posedge hclk) disable iff (!hresetn)
        ce && !document_ok && prm_reg[`KCM_IDX_SELECT] == 8'h00 |=> !online;
    endproperty
    a_online: assert property (p_online) else $error("on-line without document");

    property p_inhibit;
        @(posedge hclk) disable iff (!hresetn)
        ce && !lid_ok && prm_reg[`KCM_IDX_COVER] == 8'h00 |=> print_inhibit;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("print not inhibited");

    property p_lid_clear;
        @(posedge hclk) disable iff (!hresetn)
        ce && lid_rise |=> prm_reg[`KCM_IDX_COVER] == 8'h00 ##1
        (!print_inhibit || !$past(lid_ok) || !$past(ce));
    endproperty
    a_lid_clear: assert property (p_lid_clear) else $error("override not cleared");
endmodule
`default_nettype wire

/* File: logic/kcm_pkg.sv */
// types shared by the keypad configuration menu
package kcm_pkg;
    // ==================================
    // menu state and category
    typedef enum logic {kcm_st_idle, kcm_st_menu} kcm_state_t;
    typedef enum logic [1:0] {kcm_cat_prn, kcm_cat_com, kcm_cat_srv, kcm_cat_ovr} kcm_cat_t;
    // ==================================
    // keypad pins, one bit per key plus a digit bus
    typedef struct packed {
        logic       digit_hit;
        logic [3:0] digit;
        logic       function_code_key;
        logic       up;
        logic       enter;
        logic       clear;
    } kcm_keys_t;
    // storage write or load of one parameter
    typedef struct packed {
        logic       we;
        logic [5:0] addr;
        logic [7:0] data;
    } kcm_nvm_t;
    // function code handed to the host
    typedef struct packed {
        logic        valid;
        logic [1:0]  len;
        logic [11:0] code;
    } kcm_host_t;
endpackage

/* File: logic/kcm_regs.svh */
// register offsets, parameter indices, ranges and reset values of the keypad menu
`ifndef KCM_REGS_SVH
`define KCM_REGS_SVH
// ==================================
// bus offsets (byte addresses)
`define KCM_ADDR_STATUS 8'h00
`define KCM_ADDR_PIDX 8'h04
`define KCM_ADDR_PDATA 8'h08
`define KCM_ADDR_HOST 8'h0c
// ==================================
// parameter table layout
`define KCM_NPARAM 34
`define KCM_BASE_PRN 6'd0
`define KCM_LAST_PRN 6'd8
`define KCM_BASE_COM 6'd9
`define KCM_LAST_COM 6'd19
`define KCM_BASE_SRV 6'd20
`define KCM_LAST_SRV 6'd31
`define KCM_BASE_OVR 6'd32
`define KCM_LAST_OVR 6'd33
`define KCM_IDX_CPI 6'd1
`define KCM_IDX_QUALITY 6'd3
`define KCM_IDX_INS_START 6'd6
`define KCM_IDX_FIRST_LINE 6'd8
`define KCM_IDX_PROTO 6'd9
`define KCM_IDX_BAUD 6'd10
`define KCM_IDX_PARITY 6'd12
`define KCM_IDX_EMUL 6'd15
`define KCM_IDX_PAPER_OUT 6'd18
`define KCM_IDX_SELECT 6'd19
`define KCM_IDX_DARK_NORMAL 6'd30
`define KCM_IDX_CORRESPONDENCE_QUALITY_DARK 6'd31
`define KCM_IDX_LOCK 6'd32
`define KCM_IDX_COVER 6'd33
// ==================================
// choice encodings, ranges, reset values
`define KCM_PROTO_PARALLEL 8'h03
`define KCM_SERIAL_SKIP 6'd5
`define KCM_NO_DOCUMENT_CHOICE 8'h00
`define KCM_DOCUMENT_PRESENT_CHOICE 8'h00
`define KCM_FIRST_LINE_MAX 8'ha0
`define KCM_FIRST_LINE_RST 8'h69
`define KCM_BAUD_RST 8'h03
`define KCM_SERVICE_MAX 8'h63
`define KCM_DARK_MAX 8'h0a
`define KCM_INTERNAL_DIGIT 4'h9
`define KCM_CODE_PRN 4'h2
`define KCM_CODE_COM 4'h3
`define KCM_CODE_SRV 4'h4
`define KCM_CODE_OVR 4'h9
`define KCM_PRINT_DIGIT 4'h0
`endif

/* File: tb/kcm_operator.sv */
// keypad operator model that presses one key at a time
`timescale 1ns/100ps
`default_nettype none
module kcm_operator
    import kcm_pkg::*;
(
    // clock
    input  wire logic      hclk,
    // keypad pins
    output var  kcm_keys_t keys
);
    initial keys = '0;
    // k: 0 digit, 1 function, 2 up, 3 enter; held 3 cycles so the synchronisers see it
    task automatic press(input int k, input logic [3:0] d);
        @(posedge hclk);
        keys.digit <= d;
        @(posedge hclk);
        keys.digit_hit <= (k == 0);
        keys.function_code_key <= (k == 1);
        keys.up <= (k == 2);
        keys.enter <= (k == 3);
        repeat (3) @(posedge hclk);
        keys <= {1'b0, ~d, 4'h0}; // released digit bus shows no stale value
        repeat (4) @(posedge hclk);
    endtask
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench for the keypad configuration menu
`timescale 1ns/100ps
`default_nettype none
`include "kcm_regs.svh"
module testbench
    import kcm_pkg::*;
;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0]  htrans = '0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = '0;
    logic        hreadyout, hresp, list_req, active, pe, onl, inh;
    logic [31:0] hrdata, q;
    logic        doc = 1'b1;
    logic        lid = 1'b1;
    kcm_keys_t   keys;
    kcm_nvm_t    ld = '0;
    kcm_nvm_t    wr, wr_last;
    kcm_host_t   host;
    logic [1:0]  cat;
    logic [5:0]  idx;
    logic [7:0]  val;
    int          err_total = 0;
    int          samples_checked = 0;
    int          n_host = 0;
    int          n_list = 0;
    // 250 MHz clock
    always #2 hclk = ~hclk;
    kcm_menu dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .key_pins(keys),
        .document_pin(doc), .lid_closed_pin(lid), .nvm_ld(ld), .nvm_wr(wr), .host_out(host),
        .print_list_req(list_req), .print_list_cat(cat), .menu_active(active),
        .disp_idx(idx), .disp_value(val), .print_inhibit(inh), .paper_empty(pe), .online(onl));
    kcm_operator op (.hclk(hclk), .keys(keys));
    // one-cycle pulses are counted in the cycle they stand
    always @(posedge hclk) begin
        if (host.valid === 1'b1) n_host++;
        if (list_req === 1'b1) n_list++;
        if (wr.we === 1'b1) wr_last = wr;
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask
    // single word transfer; waits on hready, read data taken at the data-phase edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic setp(input logic [5:0] i, input logic [7:0] v);
        bus(1'b1, `KCM_ADDR_PIDX, {26'h0, i});
        bus(1'b1, `KCM_ADDR_PDATA, {24'h0, v});
    endtask
    task automatic getp(input logic [5:0] i);
        bus(1'b1, `KCM_ADDR_PIDX, {26'h0, i});
        bus(1'b0, `KCM_ADDR_PDATA, 32'h0);
    endtask
    // digits, first in the low nibble, then the function key
    task automatic code(input logic [11:0] c, input int n);
        for (int i = 0; i < n; i++) op.press(0, c[4*i +: 4]);
        op.press(1, 4'h0);
    endtask
    task automatic t_store();
        getp(6'd8); chk(q, 32'h69);
        getp(6'd10); chk(q, 32'h3);
        getp(6'd28); chk(q, 32'h0);
        bus(1'b0, 8'h10, 32'h0); chk(q, 32'h0);
        chk(hresp, 1'b0);
        setp(6'd30, 8'h0a);
        // the storage pulse follows the write edge by one cycle
        repeat (2) @(posedge hclk);
        chk(wr_last, {1'b1, 6'd30, 8'h0a});
        setp(6'd30, 8'h0b); getp(6'd30); chk(q, 32'h0a);
        ld <= {1'b1, 6'd1, 8'h02};
        @(posedge hclk);
        ld <= '0;
        getp(6'd1); chk(q, 32'h2);
        setp(6'd1, 8'h00);
        // dual port is only legal with dtr or xon/xoff flow, so protocol goes first
        setp(6'd9, 8'h01);
        setp(6'd17, 8'h01); getp(6'd17); chk(q, 32'h1);
        setp(6'd17, 8'h00);
        setp(6'd9, 8'h00);
        $display("store test done");
    endtask
    task automatic t_menu();
        int base[4] = '{0, 9, 20, 32};
        int cnt[4] = '{9, 11, 12, 2};
        logic [3:0] dg[4] = '{4'h2, 4'h3, 4'h4, 4'h9};
        for (int c = 0; c < 4; c++) begin
            code({4'h0, dg[c], 4'h9}, 2);
            chk({active, idx}, {1'b1, base[c][5:0]});
            bus(1'b0, `KCM_ADDR_STATUS, 32'h0);
            chk(q[12:4], {1'b1, c[1:0], base[c][5:0]});
            repeat (cnt[c]) op.press(3, 4'h0);
            chk(active, 1'b0);
        end
        code(12'h029, 2);
        op.press(2, 4'h0); chk(val, 8'h1);
        op.press(2, 4'h0); chk(val, 8'h0);
        op.press(3, 4'h0); chk(idx, 6'd1);
        for (int i = 1; i < 4; i++) begin
            op.press(2, 4'h0); chk(val, 8'(i % 3));
        end
        repeat (8) op.press(3, 4'h0);
        $display("menu test done");
    endtask
    task automatic t_lock();
        setp(6'd32, 8'h01);
        code(12'h029, 2);
        op.press(2, 4'h0); chk(val, 8'h0);
        repeat (9) op.press(3, 4'h0);
        setp(6'd9, 8'h03);
        code(12'h039, 2);
        op.press(3, 4'h0); chk(idx, 6'd14);
        repeat (6) op.press(3, 4'h0);
        setp(6'd9, 8'h00);
        setp(6'd32, 8'h00);
        $display("lock and skip test done");
    endtask
    task automatic t_codes();
        code(12'h021, 2); chk({n_host, host.len, host.code}, {32'd1, 2'd2, 12'h021});
        code(12'h009, 3); chk({n_list, n_host}, {32'd1, 32'd1});
        chk(cat, 2'd1);
        code(12'h059, 2); chk({n_host, 31'h0, active}, {32'd1, 32'd0});
        $display("code test done");
    endtask
    task automatic t_pins();
        doc <= 1'b0;
        repeat (4) @(posedge hclk);
        chk({pe, onl}, 2'b10);
        setp(6'd18, 8'h01); setp(6'd19, 8'h01);
        // pin outputs follow a parameter write one edge later
        repeat (2) @(posedge hclk);
        chk({pe, onl}, 2'b01);
        setp(6'd18, 8'h00); setp(6'd19, 8'h00);
        lid <= 1'b0;
        repeat (4) @(posedge hclk);
        chk(inh, 1'b1);
        setp(6'd33, 8'h01);
        repeat (2) @(posedge hclk);
        chk(inh, 1'b0);
        lid <= 1'b1;
        repeat (4) @(posedge hclk);
        getp(6'd33); chk(q, 32'h0);
        doc <= 1'b1;
        $display("pin test done");
    endtask
    // main sequence
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        t_store();
        t_menu();
        t_lock();
        t_codes();
        t_pins();
        test_done();
    end
    // watchdog far beyond the expected thousand or so cycles
    initial begin
        repeat (40000) @(posedge hclk);
        err_total++;
        test_done();
    end
endmodule
`default_nettype wire
